/* core/rivp_pkg.sv */
// Purpose: Shared constants for reset and interrupt vector placement
// Assumes: Word-addressed program memory, vectors two words apart
// Notes:   Boot start is a module parameter of the top
package rivp_pkg;

    // ========================================================
    // Widths and table layout
    localparam int PC_WIDTH      = 14;
    localparam int NUM_SOURCES   = 25;
    localparam int SRC_IDX_WIDTH = 5;

    localparam logic [PC_WIDTH-1:0] RESET_BASE_ADDR = 14'h0000;
    localparam logic [PC_WIDTH-1:0] IRQ_BASE_ADDR   = 14'h0002;
    localparam logic [PC_WIDTH-1:0] VECTOR_STRIDE   = 14'h0002;
    localparam logic [PC_WIDTH-1:0] BOOT_START_DEF  = 14'h1C00;

    // ========================================================
    // Source index order, vector number minus two
    localparam int SRC_EXT_REQ_ZERO   = 0;
    localparam int SRC_EXT_REQ_ONE    = 1;
    localparam int SRC_PIN_CHG_ZERO   = 2;
    localparam int SRC_PIN_CHG_ONE    = 3;
    localparam int SRC_PIN_CHG_TWO    = 4;
    localparam int SRC_WATCHDOG       = 5;
    localparam int SRC_TIMER2_CMP_A   = 6;
    localparam int SRC_TIMER2_CMP_B   = 7;
    localparam int SRC_TIMER2_OVF     = 8;
    localparam int SRC_TIMER1_CAPT    = 9;
    localparam int SRC_TIMER1_CMP_A   = 10;
    localparam int SRC_TIMER1_CMP_B   = 11;
    localparam int SRC_TIMER1_OVF     = 12;
    localparam int SRC_TIMER0_CMP_A   = 13;
    localparam int SRC_TIMER0_CMP_B   = 14;
    localparam int SRC_TIMER0_OVF     = 15;
    localparam int SRC_SERIAL_XFER    = 16;
    localparam int SRC_USART_RX       = 17;
    localparam int SRC_TX_DATA_EMPTY  = 18;
    localparam int SRC_USART_TX       = 19;
    localparam int SRC_CONVERSION     = 20;
    localparam int SRC_NV_DATA_READY  = 21;
    localparam int SRC_ANALOG_COMP    = 22;
    localparam int SRC_TWO_WIRE       = 23;
    localparam int SRC_PROG_STORE_RDY = 24;

    // Fuse decode: 0 programmed, 1 unprogrammed
    localparam logic FUSE_PROGRAMMED   = 1'b0;
    localparam logic FUSE_UNPROGRAMMED = 1'b1;

    typedef enum logic [1:0] {
        RIVP_IDLE     = 2'b00,
        RIVP_RESET    = 2'b01,
        RIVP_DISPATCH = 2'b10
    } rivp_state_t;

endpackage

/* core/rivp_prio_enc.sv */
// Purpose: Lowest-index-first priority encoder for pending sources
// Assumes: Request vector is already masked by enables
// Notes:   Pure combinational
`timescale 1ns/1ps
module rivp_prio_enc
    import rivp_pkg::*;
#(
    parameter int N = NUM_SOURCES
) (
    input  wire logic [N-1:0]             req,
    output logic                          any,
    output logic [SRC_IDX_WIDTH-1:0]      idx
);

    // ========================================================
    // Scan from highest down so the lowest index wins
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = SRC_IDX_WIDTH'(i);
            end
        end
    end

endmodule

/* core/rivp_vector_place.sv */
// Purpose: Vector fetch address for reset and interrupt dispatch
// Assumes: Core asserts reset_fetch or irq_accept for one cycle
// Notes:   Fetch address held in a register, valid one cycle later
//
// How it works
// - Vector one at 0x0000 taken for every reset cause.
// - Vectors 2-6 at 0x0002-0x000A serve external and pin-change requests.
// - Vector 7 watchdog; vectors 8-10 timer 2 compare A, B, overflow.
// - Vectors 11-14 timer 1; vectors 15-17 timer 0, in listed order.
// - Vector 18 serial transfer; 19-21 USART receive, empty, transmit.
// - Vectors 22-26 conversion, nv ready, comparator, two-wire, store.
// - Programmed boot fuse moves reset fetch to boot start.
// - Vector select set adds boot start to each table address.
// - Fuse picks reset address, select bit picks table; independent.
// - 2K boot section with fuse programmed resets to 0x1C00.
// - 2K boot section with select set fetches 0x1C02 to 0x1C32.
// - Outside dispatch, vector locations are plain program memory.
// - Fuse value one means unprogrammed, zero means programmed.
// - Select bit clear places table at start of flash.
`timescale 1ns/1ps
module rivp_vector_place
    import rivp_pkg::*;
#(
    parameter logic [PC_WIDTH-1:0] BOOT_START = BOOT_START_DEF
) (
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire logic                   boot_reset_fuse,
    input  wire logic                   vector_table_select,
    input  wire logic [NUM_SOURCES-1:0] irq_pending,
    input  wire logic [NUM_SOURCES-1:0] irq_enable,
    input  wire logic                   reset_fetch,
    input  wire logic                   irq_accept,
    output logic                        irq_request,
    output logic [SRC_IDX_WIDTH-1:0]    irq_index,
    output logic [PC_WIDTH-1:0]         fetch_addr_reg,
    output logic                        fetch_valid_reg,
    output logic                        fetch_is_reset_reg
);

    // ========================================================
    // Pending selection
    logic [NUM_SOURCES-1:0]   masked_req;
    logic                     any_req;
    logic [SRC_IDX_WIDTH-1:0] win_idx;

    // Disabled sources never reach dispatch
    assign masked_req = irq_pending & irq_enable;

    rivp_prio_enc #(
        .N (NUM_SOURCES)
    ) u_prio (
        .req (masked_req),
        .any (any_req),
        .idx (win_idx)
    );

    // Lowest index is lowest vector number
    assign irq_request = any_req;
    assign irq_index   = win_idx;

    // ========================================================
    // Address computation
    logic [PC_WIDTH-1:0] reset_addr;
    logic [PC_WIDTH-1:0] table_base;
    logic [PC_WIDTH-1:0] irq_addr;

    // Fuse alone picks reset target
    assign reset_addr = (boot_reset_fuse == FUSE_PROGRAMMED) ?
                        BOOT_START : RESET_BASE_ADDR;

    // Select alone picks table base
    assign table_base = vector_table_select ? BOOT_START : RESET_BASE_ADDR;

    // Table of two-word entries in source order
    assign irq_addr = PC_WIDTH'(table_base + IRQ_BASE_ADDR +
                      PC_WIDTH'(win_idx) * VECTOR_STRIDE);

    // ========================================================
    // Fetch state
    rivp_state_t state_reg;
    rivp_state_t state_next;

    always_comb begin
        state_next = RIVP_IDLE;
        case (1'b1)
            reset_fetch:          state_next = RIVP_RESET;
            irq_accept & any_req: state_next = RIVP_DISPATCH;
            default:              state_next = RIVP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= RIVP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Reset outranks dispatch; address only driven on a fetch
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_addr_reg     <= RESET_BASE_ADDR;
            fetch_valid_reg    <= 1'b0;
            fetch_is_reset_reg <= 1'b0;
        end else begin
            case (state_next)
                RIVP_RESET: begin
                    fetch_addr_reg     <= reset_addr;
                    fetch_valid_reg    <= 1'b1;
                    fetch_is_reset_reg <= 1'b1;
                end
                RIVP_DISPATCH: begin
                    fetch_addr_reg     <= irq_addr;
                    fetch_valid_reg    <= 1'b1;
                    fetch_is_reset_reg <= 1'b0;
                end
                default: begin
                    fetch_valid_reg    <= 1'b0;
                    fetch_is_reset_reg <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // Checks
    a_reset_target: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        reset_fetch |=> fetch_valid_reg && fetch_is_reset_reg &&
        fetch_addr_reg == ($past(boot_reset_fuse) ? 14'h0000 : BOOT_START))
        else $error("reset fetch address wrong");

    a_reset_zero: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (reset_fetch && boot_reset_fuse) |=> fetch_addr_reg == 14'h0000)
        else $error("reset vector not at zero");

    a_table_low: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (irq_accept && any_req && !reset_fetch && !vector_table_select)
        |=> fetch_addr_reg == 14'h0002 + 14'($past(win_idx)) * 14'h0002)
        else $error("low table address wrong");

    a_table_boot: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (irq_accept && any_req && !reset_fetch && vector_table_select)
        |=> fetch_addr_reg ==
            BOOT_START + 14'h0002 + 14'($past(win_idx)) * 14'h0002)
        else $error("boot table address wrong");

    a_table_span: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (fetch_valid_reg && !fetch_is_reset_reg && !$past(vector_table_select))
        |-> fetch_addr_reg >= 14'h0002 && fetch_addr_reg <= 14'h0032)
        else $error("vector outside table");

    a_lowest_first: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        any_req |-> (masked_req & ((NUM_SOURCES'(1) << win_idx) -
        NUM_SOURCES'(1))) == '0)
        else $error("not lowest pending");

    a_no_dispatch: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (!reset_fetch && !(irq_accept && any_req)) |=> !fetch_valid_reg)
        else $error("fetch without cause");

    a_watchdog_vec: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (irq_accept && !reset_fetch && !vector_table_select &&
         masked_req[5:0] == 6'h20) |=> fetch_addr_reg == 14'h000C)
        else $error("watchdog vector wrong");

    a_select_indep: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (reset_fetch && vector_table_select && boot_reset_fuse)
        |=> fetch_addr_reg == 14'h0000)
        else $error("select moved reset");

    // ========================================================
    // State, priority, boot address and hold checks
    a_state_valid: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        fetch_valid_reg == (state_reg != RIVP_IDLE))
        else $error("valid differs from state");

    a_state_reset: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        fetch_is_reset_reg == (state_reg == RIVP_RESET))
        else $error("reset flag differs from state");

    a_reset_wins: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (reset_fetch && irq_accept) |=> fetch_is_reset_reg)
        else $error("dispatch beat reset");

    a_boot_reset: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (reset_fetch && !boot_reset_fuse) |=> fetch_addr_reg == BOOT_START)
        else $error("boot reset address wrong");

    a_boot_span: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (fetch_valid_reg && !fetch_is_reset_reg && $past(vector_table_select))
        |-> fetch_addr_reg >= BOOT_START + 14'h0002 &&
            fetch_addr_reg <= BOOT_START + 14'h0032)
        else $error("vector outside boot table");

    a_addr_holds: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !fetch_valid_reg |-> $stable(fetch_addr_reg))
        else $error("address moved without fetch");

    a_dispatch_flag: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (irq_accept && any_req && !reset_fetch)
        |=> fetch_valid_reg && !fetch_is_reset_reg)
        else $error("dispatch fetch flags wrong");

endmodule

/* test/rivp_core_model.sv */
// Purpose: Core-side model issuing fetch requests
// Assumes: Bench commands a request one cycle ahead
// Notes:   Pulses last one cycle, changed just after the edge
`timescale 1ns/1ps
module rivp_core_model (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic go_rst,
    input  wire logic go_irq,
    output logic      reset_fetch,
    output logic      irq_accept
);
    // ========================================================
    // One-cycle request pulses
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_fetch <= 1'b0;
            irq_accept  <= 1'b0;
        end else begin
            reset_fetch <= go_rst;
            irq_accept  <= go_irq;
        end
    end
endmodule

/* test/test_rivp_vector_place.sv */
// Purpose: Self-checking bench for vector placement
// Assumes: Answer one cycle after the taking edge
// Notes:   Boot start at the 2K boot section value
`timescale 1ns/1ps
module test_rivp_vector_place import rivp_pkg::*;;
    localparam logic [PC_WIDTH-1:0] BOOT = 14'h1C00;
    logic                   ref_clk, reset_n, go_rst, go_irq;
    logic                   boot_reset_fuse, vector_table_select;
    logic [NUM_SOURCES-1:0] irq_pending, irq_enable;
    logic                   reset_fetch, irq_accept, irq_request;
    logic [SRC_IDX_WIDTH-1:0] irq_index;
    logic [PC_WIDTH-1:0]    fetch_addr_reg;
    logic                   fetch_valid_reg, fetch_is_reset_reg;
    int                     err_total, cmp_count;

    // ========================================================
    // Clock, reset, instances
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    rivp_core_model u_core (.ref_clk(ref_clk), .reset_n(reset_n),
        .go_rst(go_rst), .go_irq(go_irq), .reset_fetch(reset_fetch),
        .irq_accept(irq_accept));
    rivp_vector_place #(.BOOT_START(BOOT)) u_dut (.ref_clk(ref_clk),
        .reset_n(reset_n), .boot_reset_fuse(boot_reset_fuse),
        .vector_table_select(vector_table_select),
        .irq_pending(irq_pending), .irq_enable(irq_enable),
        .reset_fetch(reset_fetch), .irq_accept(irq_accept),
        .irq_request(irq_request), .irq_index(irq_index),
        .fetch_addr_reg(fetch_addr_reg), .fetch_valid_reg(fetch_valid_reg),
        .fetch_is_reset_reg(fetch_is_reset_reg));

    // ========================================================
    // Shared tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task fetch(input logic r, input logic a);
        @(posedge ref_clk);
        go_rst <= r;
        go_irq <= a;
        @(posedge ref_clk);
        go_rst <= 1'b0;
        go_irq <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task set_in(input logic f, input logic s, input logic [24:0] p,
                input logic [24:0] e);
        @(posedge ref_clk);
        boot_reset_fuse     <= f;
        vector_table_select <= s;
        irq_pending         <= p;
        irq_enable          <= e;
    endtask

    // ========================================================
    // Scenarios
    task scen_reset;
        logic [15:0] x;
        for (int k = 0; k < 4; k++) begin
            set_in(k[0], k[1], 25'h1FFFFFF, 25'h1FFFFFF);
            fetch(1'b1, 1'b1);
            chk(16'(fetch_valid_reg), 16'h0001);
            chk(16'(fetch_is_reset_reg), 16'h0001);
            x = k[0] ? 16'h0000 : 16'h1C00;
            chk({2'h0, fetch_addr_reg}, x);
        end
    endtask
    task scen_table;
        logic [PC_WIDTH-1:0] e;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < NUM_SOURCES; i++) begin
                set_in(1'b1, s[0], 25'(1) << i, 25'h1FFFFFF);
                fetch(1'b0, 1'b1);
                e = (s[0] ? BOOT : 14'h0000) + 14'h0002 + 14'(2 * i);
                chk(16'(irq_index), 16'(i));
                chk(16'(fetch_is_reset_reg), 16'h0000);
                chk({2'h0, fetch_addr_reg}, {2'h0, e});
            end
        end
    endtask
    task scen_prio;
        set_in(1'b1, 1'b0, 25'h1FFFFFF, 25'h1FFFFF0);
        fetch(1'b0, 1'b1);
        chk({2'h0, fetch_addr_reg}, 16'h000A);
        set_in(1'b1, 1'b0, 25'h1000080, 25'h1FFFFFF);
        fetch(1'b0, 1'b1);
        chk({2'h0, fetch_addr_reg}, 16'h0010);
    endtask
    task scen_refuse;
        set_in(1'b0, 1'b1, 25'h0000008, 25'h1FFFFF7);
        fetch(1'b0, 1'b1);
        chk(16'(irq_request), 16'h0000);
        chk(16'(fetch_valid_reg), 16'h0000);
        chk({2'h0, fetch_addr_reg}, 16'h0010);
    endtask
    task scen_midreset;
        @(posedge ref_clk);
        reset_n <= 1'b0;
        @(negedge ref_clk);
        chk({2'h0, fetch_addr_reg}, 16'h0000);
        chk(16'(fetch_valid_reg), 16'h0000);
        chk(16'(fetch_is_reset_reg), 16'h0000);
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        set_in(1'b0, 1'b0, 25'h0000001, 25'h1FFFFFF);
        fetch(1'b1, 1'b0);
        chk({2'h0, fetch_addr_reg}, 16'h1C00);
        chk(16'(fetch_is_reset_reg), 16'h0001);
        set_in(1'b0, 1'b0, 25'h0000001, 25'h1FFFFFF);
        fetch(1'b0, 1'b1);
        chk({2'h0, fetch_addr_reg}, 16'h0002);
        chk(16'(fetch_valid_reg), 16'h0001);
    endtask

    // ========================================================
    // Verdict and main sequence
    task results;
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        err_total = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        go_rst = 1'b0;
        go_irq = 1'b0;
        boot_reset_fuse = 1'b1;
        vector_table_select = 1'b0;
        irq_pending = '0;
        irq_enable = '0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        scen_reset();
        scen_table();
        scen_prio();
        scen_refuse();
        scen_midreset();
        results();
    end
endmodule
